/* hw/iacw_irq_ctrl.sv */
// Interrupt controller with comparator wake logic for a small 8-bit core
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module iacw_irq_ctrl #(
    parameter int unsigned PORT_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core instruction events
    input wire logic enable_interrupts_instr,
    input wire logic disable_interrupts_instr,
    input wire logic return_from_irq_instr,
    input wire logic sleep_instr,
    input wire logic irq_taken,
    // Core context to save and restore
    input wire logic [7:0] core_accumulator,
    input wire logic [3:0] core_status_bits,
    input wire logic [2:0] core_bank_bits,
    input wire logic [7:0] core_index,
    output logic [7:0] ctx_accumulator,
    output logic [3:0] ctx_status_bits,
    output logic [2:0] ctx_bank_bits,
    output logic [7:0] ctx_index,
    output logic ctx_restore,
    // Core control
    output logic irq_request,
    output logic [11:0] irq_vector,
    output logic sleeping,
    output logic wake_up,
    // Event sources
    input wire logic timer_counter_overflow,
    input wire logic [PORT_W-1:0] port_pins,
    input wire logic ext_irq_input_a,
    input wire logic ext_irq_input_b,
    input wire logic comparator_raw,
    // Nonvolatile option bits 8~7: filter enable, falling edge
    input wire logic [1:0] noise_option,
    // Shared pin and comparator pin control
    input wire logic shared_io_out,
    input wire logic shared_io_oe,
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe,
    output logic shared_pin_is_irq,
    output logic cmp_inputs_analog,
    output logic cmp_amplifier_mode,
    output logic comparator_enable
);
    import iacw_pkg::*;

    // All registered state of the controller apart from the noise filters
    typedef struct packed {
        logic [7:0] stat;         // Raw flags: timer, port, ext a
        logic [7:0] wake;         // Wake control: ext b flag, wake en, cmp flag
        logic [7:0] mask;         // Masks for stat, bit3 for the ext b flag in wake
        logic [7:0] wdt;          // Watchdog control, bit0 cmp irq enable
        logic [7:0] cmp;          // Comparator control, result bit live
        logic [PORT_W-1:0] port_ref; // Port reference levels
        logic cmp_ref;            // Latched comparator level
        logic cmp_prev;           // Comparator level last cycle
        logic gie;                // Global interrupt enable
        logic asleep;             // Core in sleep
        logic wake_pls;           // Wake pulse
        logic in_isr;             // Context held
        logic restore;            // Restore pulse
        logic [7:0] sh_acc;       // Shadow accumulator
        logic [3:0] sh_stat;      // Shadow status bits 5,4,1,0
        logic [2:0] sh_bank;      // Shadow bank bits
        logic [7:0] sh_idx;       // Shadow index
        logic [7:0] rdata;        // Read data register
    } iacw_state_type;

    iacw_state_type state_r;
    iacw_state_type state_nxt;

    // Filtered external edges
    logic ext_a_edge;
    logic ext_b_edge;
    // Combined pending request
    logic pending;
    logic cmp_change;
    logic port_change;

    ////////////////////////////////////////////////////////////////////////
    // Read-modify helper: keep read-only bits, take writable ones
    function automatic logic [7:0] merge_wr(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] wmask);
        merge_wr = (old_v & ~wmask) | (new_v & wmask);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Noise filters on both external inputs
    iacw_noise_filter #(.CNT_W(4)) u_filt_a (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .filter_on(noise_option[1]),
        .edge_falling(noise_option[0]),
        .stable_max(IACW_NOISE_MAX),
        .pin_in(ext_irq_input_a),
        .edge_pulse(ext_a_edge)
    );

    iacw_noise_filter #(.CNT_W(4)) u_filt_b (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .filter_on(noise_option[1]),
        .edge_falling(noise_option[0]),
        .stable_max(IACW_NOISE_MAX),
        .pin_in(ext_irq_input_b),
        .edge_pulse(ext_b_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Change detection: port against its software-latched reference
    assign port_change = (port_pins != state_r.port_ref);
    // Comparator counts as on only when its select bits use it
    assign comparator_enable = state_r.cmp[IACW_CC_SEL_HI] | state_r.cmp[IACW_CC_SEL_LO];
    // Live change against last cycle; reference only matters for wake
    assign cmp_change = comparator_enable && (comparator_raw != state_r.cmp_prev);
    // Pending interrupt: any masked-in flag
    assign pending = |(state_r.stat & state_r.mask & IACW_STAT_WMASK)
        | (state_r.wake[IACW_WK_EXT1] & state_r.mask[3])
        | (state_r.wake[IACW_WK_COMPARATOR_CHANGE_FLAG] & state_r.wdt[IACW_WD_COMPARATOR_IRQ_ENABLE]);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.wake_pls = 1'b0;
        state_nxt.restore = 1'b0;
        state_nxt.cmp_prev = comparator_raw;
        state_nxt.cmp[IACW_CC_RESULT] = comparator_raw;

        // Register writes first, so hardware sets below win over clears
        if (reg_wr) begin
            case (reg_addr)
                IACW_ADDR_IRQ_STATUS: begin
                    state_nxt.stat = merge_wr(state_r.stat, reg_wdata, IACW_STAT_WMASK);
                end
                IACW_ADDR_WAKE_CTRL: begin
                    state_nxt.wake = merge_wr(state_r.wake, reg_wdata, IACW_WAKE_WMASK);
                end
                IACW_ADDR_IRQ_MASK: begin
                    state_nxt.mask = reg_wdata & 8'h0F;
                end
                IACW_ADDR_WDT_CTRL: begin
                    state_nxt.wdt = merge_wr(state_r.wdt, reg_wdata, IACW_WDT_WMASK);
                end
                IACW_ADDR_CMP_CTRL: begin
                    state_nxt.cmp = merge_wr(state_r.cmp, reg_wdata, IACW_CMP_WMASK);
                    state_nxt.cmp[IACW_CC_RESULT] = comparator_raw;
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end

        // Reads that latch references
        if (reg_rd && reg_addr == IACW_ADDR_PORT_IN) begin
            state_nxt.port_ref = port_pins;
        end
        if (reg_rd && reg_addr == IACW_ADDR_CMP_CTRL) begin
            state_nxt.cmp_ref = comparator_raw;
        end

        // Flags set when masked in (external inputs also need their pin select), regardless of global enable
        if (timer_counter_overflow && state_r.mask[IACW_ST_TIMER]) begin
            state_nxt.stat[IACW_ST_TIMER] = 1'b1;
        end
        if (port_change && state_r.mask[IACW_ST_PORT]) begin
            state_nxt.stat[IACW_ST_PORT] = 1'b1;
        end
        if (ext_a_edge && state_r.mask[IACW_ST_EXT0] && state_r.cmp[IACW_CC_EXT_IRQ0_PIN_SELECT]) begin
            state_nxt.stat[IACW_ST_EXT0] = 1'b1;
        end
        if (ext_b_edge && state_r.mask[3] && state_r.cmp[IACW_CC_EXT_IRQ1_PIN_SELECT]) begin
            state_nxt.wake[IACW_WK_EXT1] = 1'b1;
        end
        // Comparator flag: hardware only ever sets it
        if (cmp_change) begin
            state_nxt.wake[IACW_WK_COMPARATOR_CHANGE_FLAG] = 1'b1;
        end

        // Global enable
        if (enable_interrupts_instr) begin
            state_nxt.gie = 1'b1;
        end else if (disable_interrupts_instr) begin
            state_nxt.gie = 1'b0;
        end

        // Interrupt entry: save context, block nesting
        if (irq_taken && !state_r.in_isr) begin
            state_nxt.in_isr = 1'b1;
            state_nxt.gie = 1'b0;
            state_nxt.sh_acc = core_accumulator;
            state_nxt.sh_stat = core_status_bits;
            state_nxt.sh_bank = core_bank_bits;
            state_nxt.sh_idx = core_index;
        end else if (return_from_irq_instr) begin
            state_nxt.in_isr = 1'b0;
            state_nxt.gie = 1'b1;
            state_nxt.restore = 1'b1;
        end

        // Sleep and wake
        if (sleep_instr) begin
            state_nxt.asleep = 1'b1;
        end else if (state_r.asleep) begin
            if ((port_change && state_r.mask[IACW_ST_PORT])
                || (comparator_enable && state_r.wake[IACW_WK_COMPARATOR_WAKE_ENABLE]
                    && comparator_raw != state_r.cmp_ref)
                || pending) begin
                state_nxt.asleep = 1'b0;
                state_nxt.wake_pls = 1'b1;
            end
        end

        // Read data, status views gated by masks
        case (reg_addr)
            IACW_ADDR_IRQ_STATUS: state_nxt.rdata = state_r.stat & state_r.mask
                & IACW_STAT_WMASK;
            IACW_ADDR_WAKE_CTRL: state_nxt.rdata = state_r.wake
                & {state_r.mask[3], 6'h3F, state_r.wdt[IACW_WD_COMPARATOR_IRQ_ENABLE]};
            IACW_ADDR_IRQ_MASK: state_nxt.rdata = state_r.mask;
            IACW_ADDR_WDT_CTRL: state_nxt.rdata = state_r.wdt;
            IACW_ADDR_CMP_CTRL: state_nxt.rdata = state_r.cmp;
            IACW_ADDR_PORT_IN: state_nxt.rdata = 8'(port_pins);
            IACW_ADDR_CTX_ACC: state_nxt.rdata = state_r.sh_acc;
            IACW_ADDR_CTX_MISC: state_nxt.rdata = {1'b0, state_r.sh_bank, state_r.sh_stat};
            IACW_ADDR_CTX_IDX: state_nxt.rdata = state_r.sh_idx;
            default: state_nxt.rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register the state
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = state_r.rdata;
    // Request only with global enable and outside a service routine
    assign irq_request = pending && state_r.gie && !state_r.in_isr && !state_r.asleep;
    assign irq_vector = IACW_IRQ_VECTOR;
    assign sleeping = state_r.asleep;
    // Core resumes next instruction; irq_request then vectors if enabled
    assign wake_up = state_r.wake_pls;
    assign ctx_restore = state_r.restore;
    assign ctx_accumulator = state_r.sh_acc;
    assign ctx_status_bits = state_r.sh_stat;
    assign ctx_bank_bits = state_r.sh_bank;
    assign ctx_index = state_r.sh_idx;

    // Shared pin: ext input b first, then comparator out, then I/O
    assign shared_pin_is_irq = state_r.cmp[IACW_CC_EXT_IRQ1_PIN_SELECT];
    assign cmp_inputs_analog = comparator_enable;
    assign cmp_amplifier_mode = &state_r.cmp[IACW_CC_SEL_HI:IACW_CC_SEL_LO];
    assign comparator_out_pin = state_r.cmp[IACW_CC_SEL_HI]
        ? state_r.cmp[IACW_CC_RESULT] : shared_io_out;
    assign comparator_out_pin_oe = !state_r.cmp[IACW_CC_EXT_IRQ1_PIN_SELECT]
        && (state_r.cmp[IACW_CC_SEL_HI] || shared_io_oe);
endmodule // iacw_irq_ctrl

/* hw/iacw_noise_filter.sv */
// Noise-rejecting edge detector for one external interrupt input
`timescale 1ns/1ps
module iacw_noise_filter #(
    parameter int unsigned CNT_W = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Configuration
    input wire logic filter_on,
    input wire logic edge_falling,
    input wire logic [CNT_W-1:0] stable_max,
    // Pin and result
    input wire logic pin_in,
    output logic edge_pulse
);
    import iacw_pkg::*;

    // All state of the filter
    typedef struct packed {
        logic level;              // Accepted level
        logic [CNT_W-1:0] count;  // Cycles the raw pin differed
        logic pulse;              // Registered edge event
    } iacw_nf_state_type;

    iacw_nf_state_type state_r;
    iacw_nf_state_type state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a new level is accepted after a full stable run, or at once with the filter off
    always_comb begin
        state_nxt = state_r;
        state_nxt.pulse = 1'b0;
        if (pin_in == state_r.level) begin
            // Glitch ended early, forget it
            state_nxt.count = '0;
        end else if (!filter_on || state_r.count == stable_max) begin
            state_nxt.level = pin_in;
            state_nxt.count = '0;
            // Edge polarity chosen by configuration
            state_nxt.pulse = edge_falling ? !pin_in : pin_in;
        end else begin
            state_nxt.count = state_r.count + 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign edge_pulse = state_r.pulse;
endmodule // iacw_noise_filter

/* hw/iacw_pkg.sv */
// Package: register offsets, field positions, reset values and timing for the interrupt block
package iacw_pkg;
    // Register addresses, chosen for the plain register port
    localparam logic [3:0] IACW_ADDR_IRQ_STATUS = 4'h0; // Bank-0 status, timer/port/ext0
    localparam logic [3:0] IACW_ADDR_WAKE_CTRL = 4'h1; // Bank-0 status, wake control
    localparam logic [3:0] IACW_ADDR_IRQ_MASK = 4'h2; // Bank-1 mask, timer/port/ext0
    localparam logic [3:0] IACW_ADDR_WDT_CTRL = 4'h3; // Bank-1 mask, watchdog + cmp enable
    localparam logic [3:0] IACW_ADDR_CMP_CTRL = 4'h4; // Comparator control
    localparam logic [3:0] IACW_ADDR_PORT_IN = 4'h5; // Pin-change port read
    localparam logic [3:0] IACW_ADDR_CTX_ACC = 4'h6; // Shadow accumulator
    localparam logic [3:0] IACW_ADDR_CTX_MISC = 4'h7; // Shadow status/bank bits
    localparam logic [3:0] IACW_ADDR_CTX_IDX = 4'h8; // Shadow index register
    // Status, wake, watchdog and comparator control field positions
    localparam int IACW_ST_TIMER = 0; // Timer overflow flag
    localparam int IACW_ST_PORT = 1; // Pin-change flag
    localparam int IACW_ST_EXT0 = 2; // External input a flag
    localparam int IACW_WK_COMPARATOR_CHANGE_FLAG = 0; // Comparator change flag
    localparam int IACW_WK_COMPARATOR_WAKE_ENABLE = 2; // Comparator wake enable
    localparam int IACW_WK_EXT1 = 7; // External input b flag
    localparam int IACW_WD_COMPARATOR_IRQ_ENABLE = 0; // Comparator irq enable
    localparam int IACW_CC_SEL_LO = 3; // Comparator select low bit
    localparam int IACW_CC_SEL_HI = 4; // Comparator select high bit
    localparam int IACW_CC_RESULT = 5; // Comparator result
    localparam int IACW_CC_EXT_IRQ0_PIN_SELECT = 6; // External input a pin select
    localparam int IACW_CC_EXT_IRQ1_PIN_SELECT = 7; // External input b pin select
    // Writable masks of mixed registers
    localparam logic [7:0] IACW_WAKE_WMASK = 8'h85;
    localparam logic [7:0] IACW_WDT_WMASK = 8'hBD;
    localparam logic [7:0] IACW_CMP_WMASK = 8'hD8;
    localparam logic [7:0] IACW_STAT_WMASK = 8'h07;
    // Reset values
    localparam logic [7:0] IACW_RST_ZERO = 8'h00;
    // Interrupt vector
    localparam logic [11:0] IACW_IRQ_VECTOR = 12'h008;
    // Noise filter: pulses shorter than this many clocks are rejected
    localparam int IACW_NOISE_CLKS = 8;
    localparam logic [3:0] IACW_NOISE_MAX = 4'(IACW_NOISE_CLKS - 1);
endpackage

/* tb/iacw_irq_ctrl_chk.sv */
// Port-level checker of the interrupt block, bound to its top module
`timescale 1ns/1ps
module iacw_irq_ctrl_chk
    import iacw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Core events and context
    input wire logic disable_interrupts_instr,
    input wire logic return_from_irq_instr,
    input wire logic irq_taken,
    input wire logic [7:0] core_accumulator,
    input wire logic [7:0] ctx_accumulator,
    input wire logic ctx_restore,
    input wire logic irq_request,
    input wire logic [11:0] irq_vector,
    input wire logic sleeping,
    input wire logic wake_up,
    // Shared pin
    input wire logic comparator_out_pin_oe,
    input wire logic shared_pin_is_irq,
    input wire logic cmp_amplifier_mode
);
    // One clock domain, so one clocking and one disable
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_vector_fixed: assert property (irq_vector == IACW_IRQ_VECTOR)
        else $error("vector is not the fixed entry");
    a_disable_blocks: assert property (disable_interrupts_instr |=> !irq_request)
        else $error("request after global disable");
    a_return_from_irq_instr_restores: assert property (return_from_irq_instr |=> ctx_restore)
        else $error("no restore after return");
    a_ctx_capture: assert property (irq_taken |=> ctx_accumulator == $past(core_accumulator))
        else $error("accumulator not saved on entry");
    a_unmapped_zero: assert property (reg_rd && (reg_addr > IACW_ADDR_CTX_IDX)
        |=> reg_rdata == IACW_RST_ZERO)
        else $error("unmapped read not zero");
    a_pin_to_irq: assert property (shared_pin_is_irq |-> !comparator_out_pin_oe)
        else $error("shared pin driven while external input");
    a_amp_drives: assert property (cmp_amplifier_mode && !shared_pin_is_irq
        |-> comparator_out_pin_oe)
        else $error("amplifier output not driven");
    a_sleep_quiet: assert property (sleeping |-> !irq_request)
        else $error("request while asleep");
    a_wake_pulse: assert property (wake_up |=> !wake_up)
        else $error("wake pulse longer than a cycle");
endmodule // iacw_irq_ctrl_chk
bind iacw_irq_ctrl iacw_irq_ctrl_chk u_chk (
    .sys_clk, .reset_n, .reg_addr, .reg_rd, .reg_rdata, .disable_interrupts_instr,
    .return_from_irq_instr, .irq_taken, .core_accumulator, .ctx_accumulator, .ctx_restore,
    .irq_request, .irq_vector, .sleeping, .wake_up, .comparator_out_pin_oe,
    .shared_pin_is_irq, .cmp_amplifier_mode
);

/* tb/iacw_pin_model.sv */
// Model of the external interrupt pins and the comparator's analog side
`timescale 1ns/1ps
module iacw_pin_model (
    // Clock
    input wire logic sys_clk,
    // Levels toward the block
    output logic ext_a,
    output logic ext_b,
    output logic cmp_level
);
    // Idle low from time zero
    initial begin
        ext_a = 1'b0;
        ext_b = 1'b0;
        cmp_level = 1'b0;
    end
    // Move one external input just after an edge
    task automatic set_ext(input bit which, input logic lvl);
        @(posedge sys_clk);
        if (which) ext_b <= lvl;
        else ext_a <= lvl;
    endtask
    // High for len clocks; short ones must count as noise
    task automatic pulse(input bit which, input int len);
        set_ext(which, 1'b1);
        repeat (len - 1) @(posedge sys_clk);
        set_ext(which, 1'b0);
    endtask
    // Comparator output swings to the other side
    task automatic flip_cmp();
        @(posedge sys_clk);
        cmp_level <= ~cmp_level;
    endtask
endmodule // iacw_pin_model

/* tb/irq_and_comparator_wake_logic_tb.sv */
// Self-checking bench of the interrupt and comparator wake block
`timescale 1ns/1ps
module irq_and_comparator_wake_logic_tb;
    import iacw_pkg::*;
    // Core event selectors
    localparam int I_EN = 0, I_DIS = 1, I_RET = 2, I_SLP = 3, I_TAKE = 4, I_TMR = 5;
    logic sys_clk, reset_n, reg_wr, reg_rd, irq_taken, sleep_instr, timer_counter_overflow;
    logic enable_interrupts_instr, disable_interrupts_instr, return_from_irq_instr;
    logic ext_irq_input_a, ext_irq_input_b, comparator_raw, shared_io_out, shared_io_oe;
    logic [3:0] reg_addr, core_status_bits, ctx_status_bits;
    logic [2:0] core_bank_bits, ctx_bank_bits;
    logic [7:0] reg_wdata, reg_rdata, core_accumulator, core_index, ctx_accumulator, ctx_index;
    logic [7:0] port_pins, r;
    logic [1:0] noise_option;
    logic [11:0] irq_vector;
    logic ctx_restore, irq_request, sleeping, wake_up, comparator_out_pin;
    logic comparator_out_pin_oe, shared_pin_is_irq, cmp_inputs_analog, cmp_amplifier_mode;
    logic comparator_enable;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int n_errors = 0, comparisons = 0, cycles = 0;
    iacw_irq_ctrl #(.PORT_W(8)) u_dut (
        .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .enable_interrupts_instr, .disable_interrupts_instr, .return_from_irq_instr,
        .sleep_instr, .irq_taken, .core_accumulator, .core_status_bits, .core_bank_bits,
        .core_index, .ctx_accumulator, .ctx_status_bits, .ctx_bank_bits, .ctx_index,
        .ctx_restore, .irq_request, .irq_vector, .sleeping, .wake_up,
        .timer_counter_overflow, .port_pins, .ext_irq_input_a, .ext_irq_input_b,
        .comparator_raw, .noise_option, .shared_io_out, .shared_io_oe, .comparator_out_pin,
        .comparator_out_pin_oe, .shared_pin_is_irq, .cmp_inputs_analog, .cmp_amplifier_mode,
        .comparator_enable
    );
    iacw_pin_model u_pins (.sys_clk, .ext_a(ext_irq_input_a), .ext_b(ext_irq_input_b),
        .cmp_level(comparator_raw));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One bus cycle; ends mid-cycle so outputs are settled for checks
    task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        if (w) reg_wr <= 1'b1;
        else begin
            reg_rd <= 1'b1;
            exp_q.push_back(d);
        end
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(negedge sys_clk);
    endtask
    // One-cycle core event
    task automatic ins(input int k);
        @(posedge sys_clk);
        case (k)
            I_EN: enable_interrupts_instr <= 1'b1;
            I_DIS: disable_interrupts_instr <= 1'b1;
            I_RET: return_from_irq_instr <= 1'b1;
            I_SLP: sleep_instr <= 1'b1;
            I_TAKE: irq_taken <= 1'b1;
            default: timer_counter_overflow <= 1'b1;
        endcase
        @(posedge sys_clk);
        {enable_interrupts_instr, disable_interrupts_instr, return_from_irq_instr} <= '0;
        {sleep_instr, irq_taken, timer_counter_overflow} <= '0;
        @(negedge sys_clk);
    endtask
    // Bounded wait for the wake pulse
    task automatic wait_wake();
        for (int i = 0; i < 30 && wake_up !== 1'b1; i++) @(negedge sys_clk);
        check(wake_up, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) rd_d <= reg_rd;
    // Read data appear in the cycle after the read
    always @(negedge sys_clk) begin
        if (rd_d) check(reg_rdata, exp_q.pop_front());
    end
    // Hang guard, far above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h0f28a864));
        {reg_wr, reg_rd, reg_addr, reg_wdata, noise_option, shared_io_oe} = '0;
        {enable_interrupts_instr, disable_interrupts_instr, return_from_irq_instr} = '0;
        {sleep_instr, irq_taken, timer_counter_overflow} = '0;
        shared_io_out = 1'b1;
        {core_accumulator, core_index} = 16'($urandom);
        {core_status_bits, core_bank_bits} = 7'($urandom);
        port_pins = 8'($urandom);
        reset_n = 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        // All registers clear; the port read also latches the change reference
        for (int a = 0; a < 16; a++) begin
            bus(0, 4'(a), (a == 5) ? port_pins : 8'h00);
        end
        r = 8'($urandom);
        bus(1, IACW_ADDR_WDT_CTRL, r);
        bus(0, IACW_ADDR_WDT_CTRL, r & IACW_WDT_WMASK);
        // Masked-in flag sets with interrupts off; status reads are ANDed
        bus(1, IACW_ADDR_IRQ_MASK, 8'h0F);
        ins(I_TMR);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h01);
        bus(1, IACW_ADDR_IRQ_MASK, 8'h00);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h00);
        bus(1, IACW_ADDR_IRQ_MASK, 8'h0F);
        ins(I_EN);
        check(irq_request, 1'b1);
        ins(I_TAKE);
        check({ctx_accumulator, ctx_index}, {core_accumulator, core_index});
        check({ctx_status_bits, ctx_bank_bits}, {core_status_bits, core_bank_bits});
        check(irq_request, 1'b0);
        bus(1, IACW_ADDR_IRQ_STATUS, 8'h00);
        ins(I_RET);
        ins(I_TMR);
        check(irq_request, 1'b1);
        ins(I_DIS);
        check(irq_request, 1'b0);
        bus(1, IACW_ADDR_IRQ_STATUS, 8'h00);
        // Reference read, then a pin change wakes the sleeping core
        bus(0, IACW_ADDR_PORT_IN, port_pins);
        ins(I_SLP);
        check(sleeping, 1'b1);
        @(posedge sys_clk);
        port_pins <= port_pins ^ (8'h01 << $urandom_range(7));
        wait_wake();
        check(irq_request, 1'b0);
        ins(I_EN);
        check(irq_request, 1'b1);
        ins(I_DIS);
        bus(0, IACW_ADDR_PORT_IN, port_pins);
        bus(1, IACW_ADDR_IRQ_STATUS, 8'h00);
        // Every comparator select code, general I/O not driving
        for (int s = 0; s < 4; s++) begin
            bus(1, IACW_ADDR_CMP_CTRL, 8'(s << 3));
            check({cmp_inputs_analog, comparator_enable}, {2{s != 0}});
            check({cmp_amplifier_mode, comparator_out_pin_oe}, {s == 3, s >= 2});
        end
        // Output change sets the sticky flag and drives the pin
        bus(1, IACW_ADDR_CMP_CTRL, 8'h10);
        bus(0, IACW_ADDR_CMP_CTRL, 8'h10);
        bus(1, IACW_ADDR_WDT_CTRL, 8'h01);
        bus(1, IACW_ADDR_WAKE_CTRL, 8'h04);
        u_pins.flip_cmp();
        repeat (4) @(posedge sys_clk);
        bus(0, IACW_ADDR_WAKE_CTRL, 8'h05);
        bus(0, IACW_ADDR_CMP_CTRL, 8'h30);
        check(comparator_out_pin, 1'b1);
        bus(1, IACW_ADDR_WAKE_CTRL, 8'h04);
        bus(0, IACW_ADDR_WAKE_CTRL, 8'h04);
        ins(I_SLP);
        u_pins.flip_cmp();
        wait_wake();
        // Comparator flag hidden from the read once its enable is off
        bus(1, IACW_ADDR_WDT_CTRL, 8'h00);
        bus(0, IACW_ADDR_WAKE_CTRL, 8'h04);
        // External inputs: noise rejection, then the falling edge option
        noise_option <= 2'b10;
        bus(1, IACW_ADDR_CMP_CTRL, 8'hC0);
        bus(1, IACW_ADDR_WAKE_CTRL, 8'h00);
        bus(1, IACW_ADDR_IRQ_STATUS, 8'h00);
        check(shared_pin_is_irq, 1'b1);
        u_pins.pulse(1'b0, 7);
        repeat (12) @(posedge sys_clk);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h00);
        u_pins.pulse(1'b0, 12);
        repeat (12) @(posedge sys_clk);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h04);
        u_pins.pulse(1'b1, 12);
        repeat (12) @(posedge sys_clk);
        bus(0, IACW_ADDR_WAKE_CTRL, 8'h80);
        noise_option <= 2'b11;
        bus(1, IACW_ADDR_IRQ_STATUS, 8'h00);
        u_pins.set_ext(1'b0, 1'b1);
        repeat (20) @(posedge sys_clk);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h00);
        u_pins.set_ext(1'b0, 1'b0);
        repeat (20) @(posedge sys_clk);
        bus(0, IACW_ADDR_IRQ_STATUS, 8'h04);
        repeat (2) @(posedge sys_clk);
        report_and_stop();
    end
endmodule // irq_and_comparator_wake_logic_tb
